// *** bench/mre_regfile_model.sv ***
// behavioural register file and return stack facing the executor
`timescale 1ns/10ps
module mre_regfile_model #(
   parameter logic [10:0] STACK_TOP = 11'h5A3,
   parameter logic [10:0] STACK_NEXT = 11'h2C1
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // read address from the instruction word, write port from the executor
   input wire logic [6:0] i_raddr,
   input wire logic i_file_we,
   input wire logic [6:0] i_file_waddr,
   input wire logic [7:0] i_file_wdata,
   input wire logic i_stack_pop,
   // read data and stack top back to the executor
   output logic [7:0] o_file_rdata,
   output logic [10:0] o_stack_top_entry
);
   logic [7:0] mem_r [128];
   logic [1:0] pops_r;
   // ***********************************
   // storage
   // ***********************************
   // file cells, cleared on reset, written on the store strobe
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int i = 0; i < 128; i++) begin
            mem_r[i] <= 8'h00;
         end
      end else if (i_file_we) begin
         mem_r[i_file_waddr] <= i_file_wdata;
      end
   end
   // pop counter, the next entry shows once a pop is seen
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pops_r <= 2'h0;
      end else if (i_stack_pop && pops_r != 2'h3) begin
         pops_r <= pops_r + 2'h1;
      end
   end
   // same-cycle read and the current return address
   assign o_file_rdata = mem_r[i_raddr];
   assign o_stack_top_entry = (pops_r == 2'h0) ? STACK_TOP : STACK_NEXT;
endmodule

// *** bench/tb_move_and_return_instr_exec.sv ***
// self-checking bench for the move and return executor
`timescale 1ns/10ps
module tb_move_and_return_instr_exec;
   localparam logic [10:0] TOP = 11'h5A3;
   localparam logic [10:0] NXT = 11'h2C1;
   logic clk, rst, valid, file_we, spec_we, pop, pc_load, busy, done, global_irq_enable;
   logic [13:0] instr;
   logic [7:0] rdata, wdata, swdata, acc;
   logic [10:0] stop, pc_addr;
   logic [6:0] raddr, waddr;
   logic [5:0] swaddr;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;
   // ***********************************
   // design and partner
   // ***********************************
   mre_exec dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_instr_valid(valid), .i_instr(instr),
      .i_file_rdata(rdata), .i_stack_top_entry(stop), .o_file_raddr(raddr),
      .o_file_we(file_we), .o_file_waddr(waddr), .o_file_wdata(wdata), .o_spec_we(spec_we),
      .o_spec_waddr(swaddr), .o_spec_wdata(swdata), .o_stack_pop(pop), .o_pc_load(pc_load),
      .o_pc_load_addr(pc_addr), .o_busy(busy), .o_instr_done(done), .o_acc(acc),
      .o_global_irq_enable(global_irq_enable));
   mre_regfile_model #(.STACK_TOP(TOP), .STACK_NEXT(NXT)) model (.i_sys_clk(clk),
      .i_sys_rst(rst), .i_raddr(instr[6:0]), .i_file_we(file_we), .i_file_waddr(waddr),
      .i_file_wdata(wdata), .i_stack_pop(pop), .o_file_rdata(rdata),
      .o_stack_top_entry(stop));
   // clock at 8 ns
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         bad_count++;
         complete_run();
      end
   end
   // ***********************************
   // helpers
   // ***********************************
   task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
      checked++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask
   // one word offered for one edge, outputs settled on return
   task automatic issue(input logic [13:0] w);
      @(negedge clk);
      valid = 1'b1;
      instr = w;
      @(negedge clk);
      valid = 1'b0;
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ***********************************
   // scenarios
   // ***********************************
   task automatic t_load_store();
      issue(14'h19A5);
      chk("acc", 11'h0A5, {3'h0, acc});
      chk("done", 11'h001, {10'h000, done});
      issue(14'h00DF);
      chk("file_we", 11'h001, {10'h000, file_we});
      chk("waddr", 11'h05F, {4'h0, waddr});
      chk("wdata", 11'h0A5, {3'h0, wdata});
      issue(14'h00E0);
      chk("file_we high", 11'h000, {10'h000, file_we});
      chk("done high", 11'h001, {10'h000, done});
   endtask
   task automatic t_copy();
      issue(14'h193C);
      issue(14'h085F);
      chk("acc copy", 11'h0A5, {3'h0, acc});
      chk("raddr", 11'h05F, {4'h0, raddr});
      issue(14'h193C);
      issue(14'h08DF);
      chk("acc dest", 11'h03C, {3'h0, acc});
      chk("file_we dest", 11'h000, {10'h000, file_we});
   endtask
   task automatic t_spec_nop();
      issue(14'h0012);
      chk("spec_we", 11'h001, {10'h000, spec_we});
      chk("swaddr", 11'h012, {5'h00, swaddr});
      chk("swdata", 11'h03C, {3'h0, swdata});
      issue(14'h0013);
      chk("spec_we high", 11'h000, {10'h000, spec_we});
      issue(14'h0000);
      chk("nop done", 11'h001, {10'h000, done});
      chk("nop writes", 11'h000, {9'h000, file_we, spec_we});
      chk("nop flow", 11'h000, {9'h000, pop, pc_load});
      chk("nop acc", 11'h03C, {3'h0, acc});
   endtask
   // return, with a word offered while busy that must be ignored
   task automatic t_ret(input logic [13:0] w, input logic [7:0] exp_acc, input logic exp_gie,
      input logic [10:0] exp_pc);
      @(negedge clk);
      valid = 1'b1;
      instr = w;
      @(negedge clk);
      chk("pop", 11'h001, {10'h000, pop});
      chk("pc_load", 11'h001, {10'h000, pc_load});
      chk("pc addr", exp_pc, pc_addr);
      chk("ret early done", 11'h000, {10'h000, done});
      chk("busy", 11'h001, {10'h000, busy});
      chk("gie", {10'h000, exp_gie}, {10'h000, global_irq_enable});
      instr = 14'h19EE;
      @(negedge clk);
      valid = 1'b0;
      chk("ret done", 11'h001, {10'h000, done});
      chk("ret busy", 11'h000, {10'h000, busy});
      chk("ret acc", {3'h0, exp_acc}, {3'h0, acc});
      chk("pop once", 11'h000, {10'h000, pop});
      chk("pc_load once", 11'h000, {10'h000, pc_load});
   endtask
   // ***********************************
   // main sequence
   // ***********************************
   initial begin
      rst = 1'b1;
      valid = 1'b0;
      instr = 14'h0000;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      t_load_store();
      t_copy();
      t_spec_nop();
      chk("gie reset", 11'h000, {10'h000, global_irq_enable});
      t_ret(14'h1877, 8'h77, 1'b0, TOP);
      t_ret(14'h0060, 8'h77, 1'b1, NXT);
      complete_run();
   end
endmodule

// *** verilog/mre_decode.sv ***
// instruction word classifier for the move and return executor
`timescale 1ns/10ps
module mre_decode (
   // instruction word
   input wire logic [13:0] i_instr,
   // decoded class
   output mre_pkg::mre_op_e o_op
);
   // ***********************************
   // classification, exact codes first
   // ***********************************
   always_comb begin
      o_op = mre_pkg::MRE_OP_NONE;
      if (i_instr == mre_pkg::OPC_NOP) begin
         o_op = mre_pkg::MRE_OP_NOP;
      end else if (i_instr == mre_pkg::OPC_RET_IRQ) begin
         o_op = mre_pkg::MRE_OP_RET_IRQ;
      end else if ((i_instr & mre_pkg::OPC_COPY_FILE_MASK) == mre_pkg::OPC_COPY_FILE) begin
         o_op = mre_pkg::MRE_OP_COPY_FILE;
      end else if ((i_instr & mre_pkg::OPC_LOAD_IMM_MASK) == mre_pkg::OPC_LOAD_IMM) begin
         o_op = mre_pkg::MRE_OP_LOAD_IMM;
      end else if ((i_instr & mre_pkg::OPC_LOAD_IMM_MASK) == mre_pkg::OPC_RET_IMM) begin
         o_op = mre_pkg::MRE_OP_RET_IMM;
      end else if ((i_instr & mre_pkg::OPC_STORE_FILE_MASK) == mre_pkg::OPC_STORE_FILE) begin
         o_op = mre_pkg::MRE_OP_STORE_FILE;
      end else if ((i_instr & mre_pkg::OPC_STORE_SPEC_MASK) == mre_pkg::OPC_STORE_SPEC) begin
         o_op = mre_pkg::MRE_OP_STORE_SPEC;
      end
   end
endmodule

// *** verilog/mre_exec.sv ***
// execute stage for data moves, no-operation and returns
`timescale 1ns/10ps
module mre_exec (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // fetch path
   input wire logic i_instr_valid,
   input wire logic [13:0] i_instr,
   // register file read data and stack top
   input wire logic [7:0] i_file_rdata,
   input wire logic [10:0] i_stack_top_entry,
   // register file access
   output logic [6:0] o_file_raddr,
   output logic o_file_we,
   output logic [6:0] o_file_waddr,
   output logic [7:0] o_file_wdata,
   output logic o_spec_we,
   output logic [5:0] o_spec_waddr,
   output logic [7:0] o_spec_wdata,
   // program flow
   output logic o_stack_pop,
   output logic o_pc_load,
   output logic [10:0] o_pc_load_addr,
   output logic o_busy,
   output logic o_instr_done,
   // state
   output logic [7:0] o_acc,
   output logic o_global_irq_enable
);
   mre_pkg::mre_op_e op;
   logic [7:0] acc_r, acc_nxt;
   logic gie_r, gie_nxt;
   logic fwe_r, fwe_nxt, swe_r, swe_nxt;
   logic [6:0] fwa_r, fwa_nxt;
   logic [5:0] swa_r, swa_nxt;
   logic [7:0] wd_r, wd_nxt;
   logic pop_r, pop_nxt, pcl_r, pcl_nxt, busy_r, busy_nxt, done_r, done_nxt;
   logic [10:0] pca_r, pca_nxt;
   logic [6:0] fra_r, fra_nxt;
   logic dest_file;

   // ***********************************
   // decode
   // ***********************************
   mre_decode u_dec (
      .i_instr(i_instr),
      .o_op(op)
   );
   assign dest_file = i_instr[mre_pkg::DEST_BIT];

   // ***********************************
   // next state
   // ***********************************
   always_comb begin
      acc_nxt = acc_r;
      gie_nxt = gie_r;
      fwe_nxt = 1'b0;
      swe_nxt = 1'b0;
      fwa_nxt = fwa_r;
      swa_nxt = swa_r;
      wd_nxt = wd_r;
      pop_nxt = 1'b0;
      pcl_nxt = 1'b0;
      pca_nxt = pca_r;
      busy_nxt = 1'b0;
      done_nxt = 1'b0;
      fra_nxt = i_instr[6:0];
      if (busy_r) begin
         done_nxt = 1'b1; // second cycle of a return
      end else if (i_instr_valid) begin
         case (op)
            mre_pkg::MRE_OP_COPY_FILE: begin
               done_nxt = 1'b1;
               if (i_instr[6:0] <= mre_pkg::FILE_ADDR_MAX) begin
                  if (!dest_file) begin
                     acc_nxt = i_file_rdata;
                  end
               end
            end
            mre_pkg::MRE_OP_LOAD_IMM: begin
               acc_nxt = i_instr[7:0];
               done_nxt = 1'b1;
            end
            mre_pkg::MRE_OP_STORE_FILE: begin
               done_nxt = 1'b1;
               if (i_instr[6:0] <= mre_pkg::FILE_ADDR_MAX) begin
                  fwe_nxt = dest_file;
                  fwa_nxt = i_instr[6:0];
                  wd_nxt = acc_r;
               end
            end
            mre_pkg::MRE_OP_STORE_SPEC: begin
               done_nxt = 1'b1;
               if (i_instr[5:0] <= mre_pkg::SPEC_ADDR_MAX) begin
                  swe_nxt = 1'b1;
                  swa_nxt = i_instr[5:0];
                  wd_nxt = acc_r;
               end
            end
            mre_pkg::MRE_OP_RET_IRQ: begin
               pop_nxt = 1'b1;
               pcl_nxt = 1'b1;
               pca_nxt = i_stack_top_entry;
               gie_nxt = 1'b1;
               busy_nxt = 1'b1;
            end
            mre_pkg::MRE_OP_RET_IMM: begin
               acc_nxt = i_instr[7:0];
               pop_nxt = 1'b1;
               pcl_nxt = 1'b1;
               pca_nxt = i_stack_top_entry;
               busy_nxt = 1'b1;
            end
            mre_pkg::MRE_OP_NOP: begin
               done_nxt = 1'b1;
            end
            default: begin
               done_nxt = 1'b0;
            end
         endcase
      end
   end

   // ***********************************
   // registers
   // ***********************************
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         acc_r <= mre_pkg::ACC_RESET;
         gie_r <= 1'b0;
         fwe_r <= 1'b0;
         swe_r <= 1'b0;
         fwa_r <= 7'h00;
         swa_r <= 6'h00;
         wd_r <= 8'h00;
         pop_r <= 1'b0;
         pcl_r <= 1'b0;
         pca_r <= mre_pkg::PC_RESET;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         fra_r <= 7'h00;
      end else begin
         acc_r <= acc_nxt;
         gie_r <= gie_nxt;
         fwe_r <= fwe_nxt;
         swe_r <= swe_nxt;
         fwa_r <= fwa_nxt;
         swa_r <= swa_nxt;
         wd_r <= wd_nxt;
         pop_r <= pop_nxt;
         pcl_r <= pcl_nxt;
         pca_r <= pca_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         fra_r <= fra_nxt;
      end
   end

   // ***********************************
   // outputs
   // ***********************************
   assign o_acc = acc_r;
   assign o_global_irq_enable = gie_r;
   assign o_file_we = fwe_r;
   assign o_file_waddr = fwa_r;
   assign o_file_wdata = wd_r;
   assign o_spec_we = swe_r;
   assign o_spec_waddr = swa_r;
   assign o_spec_wdata = wd_r;
   assign o_stack_pop = pop_r;
   assign o_pc_load = pcl_r;
   assign o_pc_load_addr = pca_r;
   assign o_busy = busy_r;
   assign o_instr_done = done_r;
   assign o_file_raddr = fra_r;

   // ***********************************
   // checks
   // ***********************************
   sequence s_ret_start;
      !busy_r && i_instr_valid && (op == mre_pkg::MRE_OP_RET_IRQ);
   endsequence
   sequence s_ret_finish;
      o_pc_load && o_stack_pop && o_busy ##1 o_instr_done && !o_busy;
   endsequence
   chk_ret_irq_pop: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      s_ret_start |=> s_ret_finish) else $error("return from irq did not pop");
   chk_ret_irq_gie: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      s_ret_start |=> o_global_irq_enable ##1 o_global_irq_enable)
      else $error("irq enable not set");
   chk_ret_imm: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (!busy_r && i_instr_valid && op == mre_pkg::MRE_OP_RET_IMM) |=>
      (o_acc == $past(i_instr[7:0])) && o_pc_load && o_busy ##1 o_instr_done)
      else $error("return with immediate wrong");
   chk_load_imm: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (!busy_r && i_instr_valid && op == mre_pkg::MRE_OP_LOAD_IMM) |=>
      (o_acc == $past(i_instr[7:0])) && o_instr_done && !o_busy)
      else $error("immediate load wrong");
   chk_copy_file: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (!busy_r && i_instr_valid && op == mre_pkg::MRE_OP_COPY_FILE
      && i_instr[6:0] <= mre_pkg::FILE_ADDR_MAX) |=> (o_acc == $past(i_file_rdata)))
      else $error("file copy wrong");
   chk_store_file: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (!busy_r && i_instr_valid && op == mre_pkg::MRE_OP_STORE_FILE
      && i_instr[6:0] <= mre_pkg::FILE_ADDR_MAX) |=>
      o_file_we && (o_file_wdata == $past(acc_r)) && (o_file_waddr == $past(i_instr[6:0])))
      else $error("file store wrong");
   chk_store_spec: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (!busy_r && i_instr_valid && op == mre_pkg::MRE_OP_STORE_SPEC
      && i_instr[5:0] <= mre_pkg::SPEC_ADDR_MAX) |=>
      o_spec_we && (o_spec_wdata == $past(acc_r)) && !o_file_we)
      else $error("special store wrong");
   chk_dest_routing: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      o_file_we |-> !$past(busy_r) && $past(i_instr[mre_pkg::DEST_BIT]))
      else $error("destination routing wrong");
   chk_nop_quiet: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (!busy_r && i_instr_valid && op == mre_pkg::MRE_OP_NOP) |=>
      $stable(o_acc) && !o_file_we && !o_spec_we && !o_stack_pop && !o_pc_load && o_instr_done)
      else $error("nop changed state");
endmodule

// *** verilog/mre_pkg.sv ***
// package of encodings and constants for the move and return executor
package mre_pkg;
   // ***********************************
   // widths
   // ***********************************
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int SADDR_W = 6;
   localparam int PC_W = 11;
   // ***********************************
   // encodings and masks
   // ***********************************
   localparam logic [13:0] OPC_COPY_FILE_MASK = 14'h3F80;
   localparam logic [13:0] OPC_COPY_FILE = 14'h0800;
   localparam logic [13:0] OPC_LOAD_IMM_MASK = 14'h3F00;
   localparam logic [13:0] OPC_LOAD_IMM = 14'h1900;
   localparam logic [13:0] OPC_RET_IMM = 14'h1800;
   localparam logic [13:0] OPC_STORE_FILE_MASK = 14'h3F80;
   localparam logic [13:0] OPC_STORE_FILE = 14'h0080;
   localparam logic [13:0] OPC_STORE_SPEC_MASK = 14'h3FC0;
   localparam logic [13:0] OPC_STORE_SPEC = 14'h0000;
   localparam logic [13:0] OPC_RET_IRQ = 14'h0060;
   localparam logic [13:0] OPC_NOP = 14'h0000;
   // ***********************************
   // operand limits and field positions
   // ***********************************
   localparam logic [6:0] FILE_ADDR_MAX = 7'h5F;
   localparam logic [5:0] SPEC_ADDR_MAX = 6'h12;
   localparam int DEST_BIT = 7;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [10:0] PC_RESET = 11'h000;
   localparam int RET_CYCLES = 2;
   typedef enum logic [2:0] {
      MRE_OP_NONE,
      MRE_OP_COPY_FILE,
      MRE_OP_LOAD_IMM,
      MRE_OP_STORE_FILE,
      MRE_OP_STORE_SPEC,
      MRE_OP_RET_IRQ,
      MRE_OP_RET_IMM,
      MRE_OP_NOP
   } mre_op_e;
endpackage
